// >>> src/wireless_cell_mac_header_framer.sv
// header framer and parser for the wireless cell mac unit
// Function
// [RL1] network ident at bytes 0-1
// [RL2] source address at bytes 2-3
// [RL3] destination address at bytes 4-5
// [RL4] bytes 6-20 hold type specific info
// [RL5] type, length, check at 21-26
// [RL6] type codes: 00 up, 01 down, 03 frame header
// [RL7] type bit 0 gives direction
// [RL8] frame header unit uses broadcast destination
// [RL9] frame header info word layout, 7 reserved
// [RL10] slot count is frame slot total
// [RL11] reservation request: 14 info, 1 reserved
// [RL12] link feedback: 14 info, 1 reserved
// [RL13] downlink data info all reserved
// [RL14] header-only units allowed
// [RL15] payload is cells right after header
// [RL16] preamble plus header take one slot
// [RL17] variable frame default, fixed selectable
// [RL18] lost header: scan, or sleep if fixed
// [RL19] length byte counts payload cells
// [RL20] 16-bit check value inside check field
// [RL21] map entry count 16-bit
// [RL22] entry: id bits 0-7, count 8-15
// [RL23] ascending bytes, msb first, zero padding
// [RL24] bad type or check flagged, discarded
`timescale 1ns/1ns
module wireless_cell_mac_header_framer (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic [7:0] pay_data_i,
   input wire logic pay_valid_i,
   output logic pay_ready_o,
   output logic [7:0] tx_data_o,
   output logic tx_valid_o,
   output logic tx_sof_o,
   input wire logic tx_ready_i,
   input wire logic [7:0] rx_data_i,
   input wire logic rx_valid_i,
   input wire logic rx_sof_i,
   output logic [7:0] rx_pay_data_o,
   output logic rx_pay_valid_o,
   output logic rx_hdr_ok_o,
   output logic rx_hdr_err_o,
   output logic [7:0] rx_type_o,
   output logic rx_sleep_o
);
   typedef enum logic [1:0] {TX_IDLE, TX_HDR, TX_PAY} tx_state_e;
   typedef enum logic [1:0] {RX_HUNT, RX_HDR, RX_PAY, RX_SLEEP} rx_state_e;

   function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] b);
      logic [15:0] c;
      c = crc ^ {b, 8'h00};
      for (int i = 0; i < 8; i++) begin
         c = c[15] ? ((c << 1) ^ cell_framer_pkg::CRC_POLY) : (c << 1);
      end
      return c;
   endfunction : crc16_byte

   function automatic logic type_known(input logic [7:0] t);
      return (t == cell_framer_pkg::TYPE_UP) || (t == cell_framer_pkg::TYPE_DOWN) ||
         (t == cell_framer_pkg::TYPE_FH);
   endfunction : type_known

   // register bus
   logic addr_ph;
   logic wr_pend_q;
   logic [7:0] addr_q;
   logic fixed_q;
   logic go_q;
   logic [15:0] net_q, src_q, dst_q;
   logic [7:0] ttype_q, tlen_q;
   logic [15:0] fh_slots_q, fh_map_q, fh_poll_q, fh_beacon_q;
   logic [15:0] entry_q [cell_framer_pkg::INFO_ENTRIES];
   logic [2:0] entry_wsel;
   logic [7:0] err_cnt_q;
   logic [31:0] rd_data;

   assign addr_ph = hsel_i && htrans_i[1] && hready_i;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign entry_wsel = 3'((addr_q - cell_framer_pkg::ADDR_ENTRY0) >> 2);
   assign hrdata_o = rd_data;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_pend_q <= 1'b0;
         addr_q <= 8'h00;
      end else if (addr_ph) begin
         wr_pend_q <= hwrite_i;
         addr_q <= haddr_i[7:0];
      end else begin
         wr_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fixed_q <= 1'b0; // see [RL17]
         net_q <= cell_framer_pkg::RST_WORD;
         src_q <= cell_framer_pkg::RST_WORD;
         dst_q <= cell_framer_pkg::RST_WORD;
         ttype_q <= cell_framer_pkg::RST_BYTE;
         tlen_q <= cell_framer_pkg::RST_BYTE;
         fh_slots_q <= cell_framer_pkg::RST_WORD;
         fh_map_q <= cell_framer_pkg::RST_WORD;
         fh_poll_q <= cell_framer_pkg::RST_WORD;
         fh_beacon_q <= cell_framer_pkg::RST_WORD;
         for (int i = 0; i < cell_framer_pkg::INFO_ENTRIES; i++) begin
            entry_q[i] <= cell_framer_pkg::RST_WORD;
         end
      end else if (wr_pend_q) begin
         if (addr_q == cell_framer_pkg::ADDR_CTRL) begin
            fixed_q <= hwdata_i[cell_framer_pkg::CTRL_FIXED_BIT]; // see [RL17]
         end else if (addr_q == cell_framer_pkg::ADDR_NETID) begin
            net_q <= hwdata_i[15:0];
         end else if (addr_q == cell_framer_pkg::ADDR_SRC) begin
            src_q <= hwdata_i[15:0];
         end else if (addr_q == cell_framer_pkg::ADDR_DST) begin
            dst_q <= hwdata_i[15:0];
         end else if (addr_q == cell_framer_pkg::ADDR_TXTYPE) begin
            ttype_q <= hwdata_i[7:0];
            tlen_q <= hwdata_i[15:8];
         end else if (addr_q == cell_framer_pkg::ADDR_FHCNT) begin
            fh_slots_q <= hwdata_i[15:0]; // see [RL10]
            fh_map_q <= hwdata_i[31:16]; // see [RL21]
         end else if (addr_q == cell_framer_pkg::ADDR_FHPOLL) begin
            fh_poll_q <= hwdata_i[15:0];
            fh_beacon_q <= hwdata_i[31:16];
         end else if (addr_q >= cell_framer_pkg::ADDR_ENTRY0 &&
                      addr_q <= cell_framer_pkg::ADDR_ENTRY6 && addr_q[1:0] == 2'b00) begin
            entry_q[entry_wsel] <= hwdata_i[15:0]; // see [RL22]
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         go_q <= 1'b0;
      end else begin
         go_q <= wr_pend_q && (addr_q == cell_framer_pkg::ADDR_CTRL) &&
            hwdata_i[cell_framer_pkg::CTRL_GO_BIT];
      end
   end

   // transmit path
   tx_state_e tx_state_q;
   logic [4:0] tx_idx_q;
   logic [15:0] tx_cnt_q;
   logic [15:0] tx_crc_q;
   logic [7:0] tx_data_q;
   logic tx_valid_q, tx_sof_q;
   logic tx_load;
   logic [15:0] hdr_word;
   logic [7:0] hdr_byte;
   logic [2:0] tx_entry;
   logic [15:0] dst_eff;

   assign tx_load = !tx_valid_q || tx_ready_i;
   assign tx_data_o = tx_data_q;
   assign tx_valid_o = tx_valid_q;
   assign tx_sof_o = tx_sof_q;
   assign pay_ready_o = (tx_state_q == TX_PAY) && tx_load; // see [RL15]
   assign tx_entry = 3'((tx_idx_q - cell_framer_pkg::OFS_INFO) >> 1);
   assign dst_eff = (ttype_q == cell_framer_pkg::TYPE_FH) ? cell_framer_pkg::ADDR_BCAST : dst_q; // see [RL8]

   always_comb begin
      hdr_word = 16'h0000;
      if (tx_idx_q < cell_framer_pkg::OFS_SRC) begin
         hdr_word = net_q; // see [RL1]
      end else if (tx_idx_q < cell_framer_pkg::OFS_DST) begin
         hdr_word = src_q; // see [RL2]
      end else if (tx_idx_q < cell_framer_pkg::OFS_INFO) begin
         hdr_word = dst_eff; // see [RL3]
      end else if (tx_idx_q < cell_framer_pkg::OFS_TYPE) begin
         // see [RL4]
         if (ttype_q == cell_framer_pkg::TYPE_FH) begin
            // see [RL9]
            if (tx_idx_q < cell_framer_pkg::OFS_FH_RSVD) begin
               case (tx_entry)
                  3'd0: hdr_word = fh_slots_q; // see [RL10]
                  3'd1: hdr_word = fh_map_q; // see [RL21]
                  3'd2: hdr_word = fh_poll_q;
                  default: hdr_word = fh_beacon_q;
               endcase
            end
         end else if (!ttype_q[cell_framer_pkg::TYPE_DIR_BIT]) begin
            // uplink: request or feedback entries, last byte reserved; see [RL7] [RL11] [RL12]
            if (tx_idx_q < cell_framer_pkg::OFS_INFO_RSVD) begin
               hdr_word = entry_q[tx_entry]; // see [RL22]
            end
         end
         // downlink data keeps all info bytes zero; see [RL13]
      end
   end

   always_comb begin
      hdr_byte = tx_idx_q[0] ? hdr_word[7:0] : hdr_word[15:8]; // see [RL23]
      if (tx_idx_q == cell_framer_pkg::OFS_TYPE) begin
         hdr_byte = ttype_q; // see [RL5] [RL6]
      end else if (tx_idx_q == cell_framer_pkg::OFS_LEN) begin
         hdr_byte = tlen_q; // see [RL19]
      end else if (tx_idx_q == cell_framer_pkg::OFS_CRC || tx_idx_q == cell_framer_pkg::OFS_CRC_PAD2) begin
         hdr_byte = 8'h00; // see [RL23]
      end else if (tx_idx_q == cell_framer_pkg::OFS_CRC_VAL) begin
         hdr_byte = tx_crc_q[15:8]; // see [RL20]
      end else if (tx_idx_q == cell_framer_pkg::OFS_LAST) begin
         hdr_byte = tx_crc_q[7:0];
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_state_q <= TX_IDLE;
         tx_idx_q <= 5'd0;
         tx_cnt_q <= 16'h0000;
         tx_crc_q <= cell_framer_pkg::CRC_INIT;
         tx_data_q <= 8'h00;
         tx_valid_q <= 1'b0;
         tx_sof_q <= 1'b0;
      end else begin
         case (tx_state_q)
            TX_IDLE: begin
               if (tx_load) begin
                  tx_valid_q <= 1'b0;
                  tx_sof_q <= 1'b0;
               end
               if (go_q) begin
                  tx_state_q <= TX_HDR;
                  tx_idx_q <= 5'd0;
                  tx_crc_q <= cell_framer_pkg::CRC_INIT;
                  tx_cnt_q <= 16'(tlen_q) * cell_framer_pkg::CELL_BYTES; // see [RL15] [RL19]
               end
            end
            TX_HDR: begin
               if (tx_load) begin
                  tx_data_q <= hdr_byte;
                  tx_valid_q <= 1'b1;
                  tx_sof_q <= (tx_idx_q == 5'd0);
                  if (tx_idx_q < cell_framer_pkg::OFS_CRC) begin
                     tx_crc_q <= crc16_byte(tx_crc_q, hdr_byte); // see [RL20]
                  end
                  tx_idx_q <= tx_idx_q + 5'd1;
                  if (tx_idx_q == cell_framer_pkg::OFS_LAST) begin
                     tx_state_q <= (tx_cnt_q == 16'h0000) ? TX_IDLE : TX_PAY; // see [RL14]
                  end
               end
            end
            TX_PAY: begin
               if (tx_load) begin
                  tx_sof_q <= 1'b0;
                  tx_valid_q <= pay_valid_i;
                  if (pay_valid_i) begin
                     tx_data_q <= pay_data_i;
                     tx_cnt_q <= tx_cnt_q - 16'h0001;
                     if (tx_cnt_q == 16'h0001) begin
                        tx_state_q <= TX_IDLE;
                     end
                  end
               end
            end
            default: tx_state_q <= TX_IDLE;
         endcase
      end
   end

   // receive path
   rx_state_e rx_state_q;
   logic [7:0] rx_hdr_q [27];
   logic [4:0] rx_idx_q;
   logic [15:0] rx_crc_q, rx_cnt_q, sleep_q;
   logic [15:0] rx_net_q, rx_src_q, rx_dst_q;
   logic [7:0] rx_len_q, rx_type_q, rx_pay_q;
   logic rx_pay_v_q, rx_ok_q, rx_err_q;
   logic rx_last, rx_good;
   logic [7:0] slot_div_q;
   logic slot_tick;

   assign rx_last = (rx_state_q == RX_HDR) && rx_valid_i && !rx_sof_i &&
      (rx_idx_q == cell_framer_pkg::OFS_LAST);
   assign rx_good = (rx_crc_q == {rx_hdr_q[cell_framer_pkg::OFS_CRC_VAL], rx_data_i}) &&
      (rx_hdr_q[cell_framer_pkg::OFS_CRC] == 8'h00) &&
      (rx_hdr_q[cell_framer_pkg::OFS_CRC_PAD2] == 8'h00) &&
      type_known(rx_hdr_q[cell_framer_pkg::OFS_TYPE]); // see [RL24]
   assign slot_tick = (slot_div_q == 8'(cell_framer_pkg::SLOT_CYCLES - 1));
   assign rx_pay_data_o = rx_pay_q;
   assign rx_pay_valid_o = rx_pay_v_q;
   assign rx_hdr_ok_o = rx_ok_q;
   assign rx_hdr_err_o = rx_err_q;
   assign rx_type_o = rx_type_q;
   assign rx_sleep_o = (rx_state_q == RX_SLEEP);

   // one slot per tick; see [RL16]
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         slot_div_q <= 8'h00;
      end else begin
         slot_div_q <= slot_tick ? 8'h00 : slot_div_q + 8'h01;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < 27; i++) begin
            rx_hdr_q[i] <= 8'h00;
         end
      end else if (rx_valid_i && (rx_state_q != RX_SLEEP)) begin
         if (rx_sof_i) begin
            rx_hdr_q[0] <= rx_data_i;
         end else if (rx_state_q == RX_HDR) begin
            rx_hdr_q[rx_idx_q] <= rx_data_i;
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_state_q <= RX_HUNT;
         rx_idx_q <= 5'd0;
         rx_crc_q <= cell_framer_pkg::CRC_INIT;
         rx_cnt_q <= 16'h0000;
         sleep_q <= 16'h0000;
         rx_pay_q <= 8'h00;
         rx_pay_v_q <= 1'b0;
         rx_ok_q <= 1'b0;
         rx_err_q <= 1'b0;
      end else begin
         rx_pay_v_q <= 1'b0;
         rx_ok_q <= 1'b0;
         rx_err_q <= 1'b0;
         if (rx_state_q == RX_SLEEP) begin
            // fixed frame: wait for expected frame start; see [RL18]
            if (sleep_q == 16'h0000) begin
               rx_state_q <= RX_HUNT;
            end else if (slot_tick) begin
               sleep_q <= sleep_q - 16'h0001;
            end
         end else if (rx_valid_i && rx_sof_i) begin
            rx_state_q <= RX_HDR;
            rx_idx_q <= 5'd1;
            rx_crc_q <= crc16_byte(cell_framer_pkg::CRC_INIT, rx_data_i);
         end else if (rx_valid_i && rx_state_q == RX_HDR) begin
            rx_idx_q <= rx_idx_q + 5'd1;
            if (rx_idx_q < cell_framer_pkg::OFS_CRC) begin
               rx_crc_q <= crc16_byte(rx_crc_q, rx_data_i); // see [RL20]
            end
            if (rx_last) begin
               rx_ok_q <= rx_good;
               rx_err_q <= !rx_good; // see [RL24]
               rx_cnt_q <= 16'(rx_hdr_q[cell_framer_pkg::OFS_LEN]) * cell_framer_pkg::CELL_BYTES;
               if (!rx_good) begin
                  rx_state_q <= fixed_q ? RX_SLEEP : RX_HUNT; // see [RL18]
                  sleep_q <= fh_slots_q;
               end else if (rx_hdr_q[cell_framer_pkg::OFS_LEN] == 8'h00) begin
                  rx_state_q <= RX_HUNT; // see [RL14]
               end else begin
                  rx_state_q <= RX_PAY;
               end
            end
         end else if (rx_valid_i && rx_state_q == RX_PAY) begin
            rx_pay_q <= rx_data_i; // see [RL15]
            rx_pay_v_q <= 1'b1;
            rx_cnt_q <= rx_cnt_q - 16'h0001;
            if (rx_cnt_q == 16'h0001) begin
               rx_state_q <= RX_HUNT;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_net_q <= 16'h0000;
         rx_src_q <= 16'h0000;
         rx_dst_q <= 16'h0000;
         rx_len_q <= 8'h00;
         rx_type_q <= 8'h00;
         err_cnt_q <= 8'h00;
      end else if (rx_last && rx_good) begin
         rx_net_q <= {rx_hdr_q[0], rx_hdr_q[1]};
         rx_src_q <= {rx_hdr_q[cell_framer_pkg::OFS_SRC], rx_hdr_q[cell_framer_pkg::OFS_SRC + 5'd1]};
         rx_dst_q <= {rx_hdr_q[cell_framer_pkg::OFS_DST], rx_hdr_q[cell_framer_pkg::OFS_DST + 5'd1]};
         rx_len_q <= rx_hdr_q[cell_framer_pkg::OFS_LEN];
         rx_type_q <= rx_hdr_q[cell_framer_pkg::OFS_TYPE];
      end else if (rx_last && err_cnt_q != 8'hFF) begin
         err_cnt_q <= err_cnt_q + 8'h01;
      end
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      if (addr_q == cell_framer_pkg::ADDR_CTRL) begin
         rd_data = {31'h0, fixed_q};
      end else if (addr_q == cell_framer_pkg::ADDR_NETID) begin
         rd_data = {16'h0, net_q};
      end else if (addr_q == cell_framer_pkg::ADDR_SRC) begin
         rd_data = {16'h0, src_q};
      end else if (addr_q == cell_framer_pkg::ADDR_DST) begin
         rd_data = {16'h0, dst_q};
      end else if (addr_q == cell_framer_pkg::ADDR_TXTYPE) begin
         rd_data = {16'(tlen_q) + cell_framer_pkg::HDR_SLOTS, tlen_q, ttype_q}; // see [RL16]
      end else if (addr_q == cell_framer_pkg::ADDR_FHCNT) begin
         rd_data = {fh_map_q, fh_slots_q};
      end else if (addr_q == cell_framer_pkg::ADDR_FHPOLL) begin
         rd_data = {fh_beacon_q, fh_poll_q};
      end else if (addr_q >= cell_framer_pkg::ADDR_ENTRY0 &&
                   addr_q <= cell_framer_pkg::ADDR_ENTRY6 && addr_q[1:0] == 2'b00) begin
         rd_data = {16'h0, entry_q[entry_wsel]};
      end else if (addr_q == cell_framer_pkg::ADDR_STATUS) begin
         rd_data = {8'h0, rx_type_q, err_cnt_q, 5'h0, (rx_state_q == RX_HUNT),
            (rx_state_q == RX_SLEEP), (tx_state_q != TX_IDLE)};
      end else if (addr_q == cell_framer_pkg::ADDR_RXADDR) begin
         rd_data = {rx_src_q, rx_net_q};
      end else if (addr_q == cell_framer_pkg::ADDR_RXINFO) begin
         rd_data = {rx_dst_q, 8'h0, rx_len_q};
      end
   end

   AST_TX_NETID: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RL1]
      (tx_state_q == TX_HDR && tx_load && tx_idx_q == 5'd0) |=> (tx_sof_q && tx_data_q == net_q[15:8]))
      else $error("network ident byte wrong");
   AST_TX_BCAST: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RL8]
      (tx_state_q == TX_HDR && tx_load && tx_idx_q == 5'd4 && ttype_q == 8'h03) |=> tx_data_q == 8'hFF)
      else $error("frame header destination not broadcast");
   AST_TX_TYPE: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RL5]
      (tx_state_q == TX_HDR && tx_load && tx_idx_q == 5'd21) |=> tx_data_q == $past(ttype_q))
      else $error("type byte wrong");
   AST_TX_LEN: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RL19]
      (tx_state_q == TX_HDR && tx_load && tx_idx_q == 5'd22) |=> tx_data_q == $past(tlen_q))
      else $error("length byte wrong");
   AST_TX_PAD: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RL23]
      (tx_state_q == TX_HDR && tx_load && (tx_idx_q == 5'd23 || tx_idx_q == 5'd24)) |=> tx_data_q == 8'h00)
      else $error("check padding not zero");
   AST_TX_EMPTY: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RL14]
      (tx_state_q == TX_HDR && tx_load && tx_idx_q == 5'd26 && tlen_q == 8'h00) |=> tx_state_q == TX_IDLE)
      else $error("header-only unit did not end");
   AST_TX_RSVD: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RL13]
      (tx_state_q == TX_HDR && tx_load && tx_idx_q > 5'd5 && tx_idx_q < 5'd21 && ttype_q == 8'h01)
      |=> tx_data_q == 8'h00) else $error("downlink info byte not zero");
   AST_RX_BADTYPE: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RL24]
      (rx_last && !type_known(rx_hdr_q[21])) |=> (rx_hdr_err_o && !rx_hdr_ok_o) ##1 !rx_pay_valid_o)
      else $error("unknown type not flagged");
   AST_RX_SCAN: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RL18]
      (rx_hdr_err_o && !fixed_q) |-> rx_state_q == RX_HUNT)
      else $error("variable mode stopped scanning");
   AST_RX_SLEEP: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RL18]
      (rx_hdr_err_o && fixed_q && fh_slots_q != 16'h0000) |-> rx_sleep_o [*2])
      else $error("fixed mode did not sleep");
endmodule : wireless_cell_mac_header_framer

// >>> src/cell_framer_pkg.sv
// constants shared by the wireless cell header framer
package cell_framer_pkg;
   // header layout, byte offsets
   localparam logic [4:0] HDR_BYTES = 5'd27;
   localparam logic [4:0] OFS_SRC = 5'd2;
   localparam logic [4:0] OFS_DST = 5'd4;
   localparam logic [4:0] OFS_INFO = 5'd6;
   localparam logic [4:0] OFS_FH_RSVD = 5'd14;
   localparam logic [4:0] OFS_INFO_RSVD = 5'd20;
   localparam logic [4:0] OFS_TYPE = 5'd21;
   localparam logic [4:0] OFS_LEN = 5'd22;
   localparam logic [4:0] OFS_CRC = 5'd23;
   localparam logic [4:0] OFS_CRC_PAD2 = 5'd24;
   localparam logic [4:0] OFS_CRC_VAL = 5'd25;
   localparam logic [4:0] OFS_LAST = 5'd26;
   localparam int INFO_ENTRIES = 7;
   // type codes
   localparam logic [7:0] TYPE_UP = 8'h00;
   localparam logic [7:0] TYPE_DOWN = 8'h01;
   localparam logic [7:0] TYPE_FH = 8'h03;
   localparam int TYPE_DIR_BIT = 0;
   localparam logic [15:0] ADDR_BCAST = 16'hFFFF;
   // check value, generator and start value still open
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   // cell and slot timing
   localparam logic [15:0] CELL_BYTES = 16'h0036;
   localparam int CLK_PERIOD_NS = 20;
   localparam int SLOT_TIME_NS = 1080;
   localparam int SLOT_CYCLES = (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [15:0] HDR_SLOTS = 16'h0001;
   // register map, byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_NETID = 8'h04;
   localparam logic [7:0] ADDR_SRC = 8'h08;
   localparam logic [7:0] ADDR_DST = 8'h0C;
   localparam logic [7:0] ADDR_TXTYPE = 8'h10;
   localparam logic [7:0] ADDR_FHCNT = 8'h14;
   localparam logic [7:0] ADDR_FHPOLL = 8'h18;
   localparam logic [7:0] ADDR_ENTRY0 = 8'h1C;
   localparam logic [7:0] ADDR_ENTRY6 = 8'h34;
   localparam logic [7:0] ADDR_STATUS = 8'h38;
   localparam logic [7:0] ADDR_RXADDR = 8'h3C;
   localparam logic [7:0] ADDR_RXINFO = 8'h40;
   localparam int CTRL_FIXED_BIT = 0;
   localparam int CTRL_GO_BIT = 1;
   // reset values
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [7:0] RST_BYTE = 8'h00;
endpackage : cell_framer_pkg

// >>> sim/phy_model.sv
// physical layer modem model: stalling byte sink and replay source
`timescale 1ns/1ns
module phy_model (
   input wire logic clk_i,
   input wire logic [7:0] tx_data_i,
   input wire logic tx_valid_i,
   input wire logic tx_sof_i,
   output logic tx_ready_o,
   output logic [7:0] rx_data_o,
   output logic rx_valid_o,
   output logic rx_sof_o
);
   logic [7:0] cap [0:63];
   int cnt = 0;
   logic [1:0] cyc = 2'h0;
   initial begin
      tx_ready_o = 1'b0;
      rx_data_o = 8'h00;
      rx_valid_o = 1'b0;
      rx_sof_o = 1'b0;
   end
   // stalls one cycle in four
   always @(posedge clk_i) begin
      cyc <= cyc + 2'h1;
      tx_ready_o <= (cyc != 2'h3);
      if (tx_valid_i && tx_ready_o) begin
         cap[tx_sof_i ? 0 : cnt] <= tx_data_i;
         cnt <= tx_sof_i ? 1 : cnt + 1;
      end
   end
   // replays the captured header, one byte damaged on request
   task automatic send(input int n, input int bad);
      for (int i = 0; i < n; i++) begin
         rx_data_o <= (i == bad) ? ~cap[i] : cap[i];
         rx_valid_o <= 1'b1;
         rx_sof_o <= (i == 0);
         @(posedge clk_i);
      end
      rx_data_o <= ~rx_data_o;
      rx_valid_o <= 1'b0;
      rx_sof_o <= 1'b0;
   endtask : send
endmodule : phy_model

// >>> sim/wireless_cell_mac_header_framer_tb.sv
// self-checking bench for the cell header framer
`timescale 1ns/1ns
module wireless_cell_mac_header_framer_tb;
   logic clk = 1'b0, rst = 1'b1, hwrite = 1'b0, hready, hresp, pay_ready;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [7:0] tx_data, rx_data, rx_pay_data, rx_type;
   logic tx_valid, tx_sof, tx_ready, rx_valid, rx_sof, rx_pay_valid, rx_ok, rx_err, rx_sleep;
   logic [7:0] ex [0:26];
   logic pv = 1'b0;
   logic [7:0] pay_got = 8'h00;
   int fails = 0, total_checks = 0;
   always #10 clk = ~clk;
   wireless_cell_mac_header_framer dut (.sys_clk_i(clk), .rst_i(rst), .hsel_i(1'b1),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
      .hresp_o(hresp), .pay_data_i(8'h5A), .pay_valid_i(pv), .pay_ready_o(pay_ready),
      .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_sof_o(tx_sof), .tx_ready_i(tx_ready),
      .rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_sof_i(rx_sof),
      .rx_pay_data_o(rx_pay_data), .rx_pay_valid_o(rx_pay_valid), .rx_hdr_ok_o(rx_ok),
      .rx_hdr_err_o(rx_err), .rx_type_o(rx_type), .rx_sleep_o(rx_sleep));
   phy_model phy (.clk_i(clk), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
      .tx_sof_i(tx_sof), .tx_ready_o(tx_ready), .rx_data_o(rx_data),
      .rx_valid_o(rx_valid), .rx_sof_o(rx_sof));
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // waits for hready sampled high at a rising edge, returns read data at that edge
   task automatic rdy(output logic [31:0] r);
      int i;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (hready === 1'b1) break;
      end
      if (i == 50) begin
         fails++;
         test_done();
      end
      r = hrdata;
   endtask : rdy
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= w;
      rdy(r);
      htrans <= 2'h0;
      hwdata <= d;
      rdy(r);
   endtask : bus
   function automatic logic [15:0] crc16;
      logic [15:0] c;
      c = cell_framer_pkg::CRC_INIT;
      for (int i = 0; i < 23; i++)
         for (int b = 7; b >= 0; b--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ ex[i][b]) ? cell_framer_pkg::CRC_POLY : 16'h0);
      return c;
   endfunction : crc16
   task automatic go_check;
      logic [31:0] r;
      int i;
      {ex[25], ex[26]} = crc16();
      phy.cnt = 0;
      bus(1'b1, cell_framer_pkg::ADDR_CTRL, 32'h00000002, r);
      for (i = 0; i < 300 && phy.cnt < 27; i++) @(posedge clk);
      if (i == 300) begin
         fails++;
         test_done();
      end
      for (i = 0; i < 27; i++) chk({24'h0, phy.cap[i]}, {24'h0, ex[i]});
   endtask : go_check
   task automatic loopback(input int bad, input logic eok);
      logic ok = 1'b0, er = 1'b0;
      fork
         phy.send(28, bad);
         for (int i = 0; i < 32; i++) begin
            @(negedge clk);
            ok = ok | rx_ok;
            er = er | rx_err;
            if (rx_pay_valid === 1'b1) pay_got = rx_pay_data;
         end
      join
      @(posedge clk);
      chk({31'h0, ok}, {31'h0, eok});
      chk({31'h0, er}, {31'h0, !eok});
   endtask : loopback
   task automatic t_fh;
      logic [31:0] r;
      bus(1'b1, cell_framer_pkg::ADDR_NETID, 32'h0000A1B2, r);
      bus(1'b1, cell_framer_pkg::ADDR_SRC, 32'h00001234, r);
      bus(1'b1, cell_framer_pkg::ADDR_DST, 32'h00005555, r);
      bus(1'b1, cell_framer_pkg::ADDR_TXTYPE, 32'h00000003, r);
      bus(1'b1, cell_framer_pkg::ADDR_FHCNT, 32'h0005002A, r);
      bus(1'b1, cell_framer_pkg::ADDR_FHPOLL, 32'h00095678, r);
      bus(1'b0, cell_framer_pkg::ADDR_TXTYPE, 32'h0, r);
      chk(r, 32'h00010003);
      bus(1'b0, 8'hFC, 32'h0, r);
      chk(r, 32'h0);
      ex = '{8'hA1, 8'hB2, 8'h12, 8'h34, 8'hFF, 8'hFF, 8'h00, 8'h2A, 8'h00, 8'h05,
         8'h56, 8'h78, 8'h00, 8'h09, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
         8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      go_check();
      loopback(-1, 1'b1);
      chk({24'h0, rx_type}, 32'h00000003);
      loopback(5, 1'b0);
      chk({31'h0, rx_sleep}, 32'h0);
   endtask : t_fh
   task automatic t_up;
      logic [31:0] r;
      bus(1'b1, cell_framer_pkg::ADDR_TXTYPE, 32'h00000100, r);
      bus(1'b1, cell_framer_pkg::ADDR_ENTRY0, 32'h0000073C, r);
      {ex[4], ex[5], ex[6], ex[7]} = 32'h5555073C;
      for (int i = 8; i < 22; i++) ex[i] = 8'h00;
      ex[22] = 8'h01;
      pv <= 1'b1;
      go_check();
      loopback(-1, 1'b1);
      chk({24'h0, pay_got}, 32'h0000005A);
      repeat (80) @(posedge clk);
      chk(phy.cnt, 32'd81);
      chk({24'h0, phy.cap[63]}, 32'h0000005A);
      pv <= 1'b0;
      bus(1'b1, cell_framer_pkg::ADDR_TXTYPE, 32'h00000001, r);
      {ex[6], ex[7], ex[21], ex[22]} = 32'h00000100;
      go_check();
      bus(1'b1, cell_framer_pkg::ADDR_CTRL, 32'h00000001, r);
      loopback(21, 1'b0);
      chk({31'h0, rx_sleep}, 32'h00000001);
   endtask : t_up
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_fh();
      t_up();
      test_done();
   end
endmodule : wireless_cell_mac_header_framer_tb
